// File: rtl/rx_path_pkg.sv
// Purpose: Shared constants for the receive gain, power, filter and demodulator path.
// Assumes: Power levels are carried in half-dB units; reference clock is 200 MHz.
// Notes:   Register offsets are byte addresses on the APB slave.
package rx_path_pkg;
   // Register map.
   localparam logic [7:0] A_THR14  = 8'h00;
   localparam logic [7:0] A_THR5   = 8'h04;
   localparam logic [7:0] A_POWER  = 8'h08;
   localparam logic [7:0] A_BW     = 8'h0c;
   localparam logic [7:0] A_ONOFF  = 8'h10;
   localparam logic [7:0] A_DEMOD  = 8'h14;
   localparam logic [7:0] A_STATUS = 8'h18;
   // Values after reset.
   localparam logic [31:0] RST_THR14     = 32'h2e241a10;
   localparam logic [7:0]  RST_THR5      = 8'h38;
   localparam logic [4:0]  RST_REF_OFF   = 5'h00;
   localparam logic [4:0]  RST_PWR_OFF   = 5'h00;
   localparam logic [2:0]  RST_DEPTH     = 3'h2;
   localparam logic [1:0]  RST_MANT      = 2'h1;
   localparam logic [2:0]  RST_EXP       = 3'h5;
   localparam logic [2:0]  RST_STEP      = 3'h0;
   localparam logic [2:0]  RST_PERIOD    = 3'h0;
   localparam logic [7:0]  RST_FLOOR     = 8'h0c;
   localparam logic [15:0] RST_BIT_PER   = 16'h0100;
   // Level arithmetic, all in half-dB.
   localparam logic signed [10:0] NOISE_HDB = -11'sh15c;
   localparam logic signed [10:0] SNR_HDB   = 11'sh010;
   localparam logic signed [10:0] LOG_M16   = 11'sh078;
   localparam logic signed [10:0] LOG_M20   = 11'sh076;
   localparam logic signed [10:0] LOG_M24   = 11'sh074;
   localparam logic [3:0]         EXP_HDB   = 4'h6;
   localparam logic [7:0]         PEAK_DROP = 8'h0c;
   localparam logic [7:0]         CAL_REF   = 8'h50;
   // Gain step codes, highest gain first.
   localparam logic [2:0] GAIN_CODE [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
   typedef enum logic [1:0] {
      ONOFF_PEAK  = 2'b00,
      ONOFF_FIXED = 2'b01,
      ONOFF_AVG   = 2'b10
   } onoff_mode_t;
   // Symmetric low-pass channel filter coefficients.
   localparam logic signed [7:0] FIR_COEF [16] = '{
      -8'sh02, -8'sh03, 8'sh00, 8'sh08, 8'sh12, 8'sh1e, 8'sh28, 8'sh2d,
      8'sh2d, 8'sh28, 8'sh1e, 8'sh12, 8'sh08, 8'sh00, -8'sh03, -8'sh02};
endpackage

// File: rtl/channel_fir.sv
// Purpose: Sixteen-tap FIR channel filter with registered output.
// Assumes: One input sample per in_valid; coefficients from the package.
// Notes:   Output is scaled back to the input width by dropping the gain bits.
`timescale 1ns/10ps
module channel_fir #(
   parameter int TAPS = 16,
   parameter int W    = 16
) (
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   input  wire logic                in_valid,
   input  wire logic signed [W-1:0] in_sample,
   output logic                     out_valid,
   output logic signed [W-1:0]      out_sample
);
   localparam int SW = W + 12;
   logic signed [W-1:0]  line_q [TAPS];
   logic signed [SW-1:0] acc;

   if (TAPS != 16) begin : g_chk
      $error("channel_fir supports exactly 16 taps");
   end

   always_comb begin
      acc = '0;
      for (int i = 0; i < TAPS; i++) begin
         // Widen both factors first, so the product keeps all of its bits.
         acc = acc + SW'(line_q[i]) * SW'(rx_path_pkg::FIR_COEF[i]);
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < TAPS; i++) begin
            line_q[i] <= '0;
         end
      end else if (in_valid) begin
         line_q[0] <= in_sample;
         for (int i = 1; i < TAPS; i++) begin
            line_q[i] <= line_q[i-1];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         out_valid  <= 1'b0;
         out_sample <= '0;
      end else begin
         out_valid  <= in_valid;
         out_sample <= acc[SW-1:SW-W];
      end
   end
endmodule // channel_fir

// File: rtl/rx_path.sv
// Purpose: Receive gain selection, power reading, channel filter and demodulators.
// Assumes: level_sample is minus twice the antenna level in dBm, one per level_valid.
// Notes:   Configuration and status sit behind an APB slave with one wait state.
// Function
// (RULE_01) Pick gain step one to six against five thresholds, codes 001..111.
// (RULE_02) Thresholds sit above -174 dBm plus 10log(2BW) plus 8 dB plus offset.
// (RULE_03) Power reading is minus twice the level plus offset, half-dB steps.
// (RULE_04) Reading offset is signed, 1 dB steps, -16 to +15 dB; the code adds it in half-dB steps, -8 to +7.5 dB.
// (RULE_05) Software negates the reading and halves it for dBm.
// (RULE_06) Average over two to the depth plus one samples.
// (RULE_07) Averaged reading settles after the window of samples.
// (RULE_08) Channel filtering by a 16-tap FIR.
// (RULE_09) Software keeps bit rate under twice the channel bandwidth.
// (RULE_10) Bandwidth from mantissa 16/20/24 and exponent 1..7; others reserved.
// (RULE_11) Bandwidth values assume a 32 MHz crystal.
// (RULE_12) Transmitter keeps modulation index within 0.5 to 10.
// (RULE_13) FSK data can pass the bit synchronizer in continuous mode.
// (RULE_14) OOK bit is power compared against one of three threshold modes.
// (RULE_15) Software should select the peak threshold mode.
// (RULE_16) Power measurement calibrates when the calibration sequence starts.
// (RULE_17) Peak threshold is peak minus 6 dB; peak decays during zeros.
// (RULE_18) Peak decay stops at the floor threshold.
// (RULE_19) Fixed mode uses the floor; average mode uses averaged power.
// (RULE_20) Reading updates once per window and holds between windows.
`timescale 1ns/10ps
module rx_path #(
   parameter int TAPS = 16,
   parameter int W    = 16
) (
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                level_valid,
   input  wire logic [7:0]          level_sample,
   input  wire logic [7:0]          cal_level,
   input  wire logic                disc_valid,
   input  wire logic signed [W-1:0] disc_sample,
   output logic [2:0]               front_amp_gain_code,
   output logic [7:0]               signal_power_reading,
   output logic                     data_out,
   output logic                     data_clk
);
   logic [31:0]       thr14_q;
   logic [7:0]        thr5_q;
   logic [4:0]        ref_off_q, pwr_off_q;
   logic [2:0]        depth_q, exp_q, step_q, period_q;
   logic [1:0]        mant_q;
   logic [1:0]        sel_q;
   logic [7:0]        floor_q;
   logic              ook_q, sync_en_q, cal_start;
   logic [15:0]       bit_per_q;
   logic              wr, rd;

   if (TAPS != 16 || W < 8) begin : g_chk
      $error("rx_path needs 16 taps and a sample width of at least 8");
   end

   // One wait state: pready rises in the second access cycle.
   assign wr = psel & penable & pready & pwrite;
   assign rd = psel & penable & ~pready;
   assign cal_start = wr && paddr == rx_path_pkg::A_POWER && pwdata[16];

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= rd;
         pslverr <= 1'b0;
         // Only reads touch the read data, so a write never disturbs it or raises an error.
         if (rd && !pwrite) begin
            if (paddr == rx_path_pkg::A_THR14) begin
               prdata <= thr14_q;
            end else if (paddr == rx_path_pkg::A_THR5) begin
               prdata <= {16'h0, thr5_q, 3'h0, ref_off_q};
            end else if (paddr == rx_path_pkg::A_POWER) begin
               prdata <= {21'h0, depth_q, 3'h0, pwr_off_q};
            end else if (paddr == rx_path_pkg::A_BW) begin
               prdata <= {27'h0, mant_q, exp_q};
            end else if (paddr == rx_path_pkg::A_ONOFF) begin
               prdata <= {16'h0, floor_q, period_q, step_q, sel_q};
            end else if (paddr == rx_path_pkg::A_DEMOD) begin
               prdata <= {bit_per_q, 14'h0, sync_en_q, ook_q};
            end else if (paddr == rx_path_pkg::A_STATUS) begin
               prdata <= {21'h0, front_amp_gain_code, signal_power_reading};
            end else begin
               prdata  <= 32'h0;
               pslverr <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         thr14_q   <= rx_path_pkg::RST_THR14;
         thr5_q    <= rx_path_pkg::RST_THR5;
         ref_off_q <= rx_path_pkg::RST_REF_OFF;
         pwr_off_q <= rx_path_pkg::RST_PWR_OFF;
         depth_q   <= rx_path_pkg::RST_DEPTH;
         mant_q    <= rx_path_pkg::RST_MANT;
         exp_q     <= rx_path_pkg::RST_EXP;
         sel_q     <= rx_path_pkg::ONOFF_PEAK;
         step_q    <= rx_path_pkg::RST_STEP;
         period_q  <= rx_path_pkg::RST_PERIOD;
         floor_q   <= rx_path_pkg::RST_FLOOR;
         ook_q     <= 1'b0;
         sync_en_q <= 1'b1;
         bit_per_q <= rx_path_pkg::RST_BIT_PER;
      end else if (wr) begin
         if (paddr == rx_path_pkg::A_THR14) begin
            thr14_q <= pwdata;
         end else if (paddr == rx_path_pkg::A_THR5) begin
            thr5_q    <= pwdata[15:8];
            ref_off_q <= pwdata[4:0];
         end else if (paddr == rx_path_pkg::A_POWER) begin
            pwr_off_q <= pwdata[4:0]; // RULE_04
            depth_q   <= pwdata[10:8];
         end else if (paddr == rx_path_pkg::A_BW) begin
            // Reserved combinations are dropped so the gain reference never uses an undefined bandwidth.
            if (pwdata[4:3] != 2'h3 && pwdata[2:0] != 3'h0) begin // RULE_10
               mant_q <= pwdata[4:3];
               exp_q  <= pwdata[2:0];
            end
         end else if (paddr == rx_path_pkg::A_ONOFF) begin
            if (pwdata[1:0] != 2'h3) begin
               sel_q <= pwdata[1:0];
            end
            step_q   <= pwdata[4:2];
            period_q <= pwdata[7:5];
            floor_q  <= pwdata[15:8];
         end else if (paddr == rx_path_pkg::A_DEMOD) begin
            ook_q     <= pwdata[0];
            sync_en_q <= pwdata[1];
            bit_per_q <= (pwdata[31:17] == 15'h0) ? 16'h0002 : pwdata[31:16];
         end
      end
   end

   // Gain control: reference level from bandwidth, then count thresholds passed.
   logic signed [10:0] log_bw, ref_hdb, pin_hdb;
   logic [2:0]         above;
   always_comb begin
      if (mant_q == 2'h0) begin
         log_bw = rx_path_pkg::LOG_M16;
      end else if (mant_q == 2'h1) begin
         log_bw = rx_path_pkg::LOG_M20;
      end else begin
         log_bw = rx_path_pkg::LOG_M24;
      end
      ref_hdb = rx_path_pkg::NOISE_HDB + log_bw + rx_path_pkg::SNR_HDB // RULE_02
              - 11'(exp_q) * 11'(rx_path_pkg::EXP_HDB)
              + {{5{ref_off_q[4]}}, ref_off_q, 1'b0};
      pin_hdb = -$signed({3'h0, level_sample});
      above = 3'h0;
      for (int i = 0; i < 5; i++) begin
         if (pin_hdb > ref_hdb + $signed({2'h0, (i < 4) ? thr14_q[8*i +: 8] : thr5_q, 1'b0})) begin
            above = above + 3'h1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         front_amp_gain_code <= rx_path_pkg::GAIN_CODE[0];
      end else if (level_valid) begin
         front_amp_gain_code <= rx_path_pkg::GAIN_CODE[above]; // RULE_01
      end
   end

   // Calibration captures the error against the internal reference source.
   logic signed [8:0] cal_q;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cal_q <= 9'sh000;
      end else if (cal_start) begin
         cal_q <= $signed({1'b0, rx_path_pkg::CAL_REF}) - $signed({1'b0, cal_level}); // RULE_16
      end
   end

   // Power averaging window.
   logic [8:0]         win_cnt_q;
   logic [15:0]        sum_q;
   logic [15:0]        sum_all;
   logic [7:0]         avg;
   logic signed [10:0] comp;
   logic               win_end;
   assign win_end = level_valid && win_cnt_q == 9'((9'h2 << depth_q) - 9'h1); // RULE_06
   always_comb begin
      sum_all = sum_q + {8'h0, level_sample};
      avg     = 8'(sum_all >> (4'(depth_q) + 4'h1));
      comp    = $signed({3'h0, avg}) + {{6{pwr_off_q[4]}}, pwr_off_q} // RULE_03
              + {{2{cal_q[8]}}, cal_q};
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         win_cnt_q            <= 9'h0;
         sum_q                <= 16'h0;
         signal_power_reading <= 8'hff;
      end else if (level_valid) begin
         if (win_end) begin // RULE_07
            win_cnt_q <= 9'h0;
            sum_q     <= 16'h0;
            // Clamp so a large offset never wraps a strong signal into a weak one.
            if (comp < 0) begin // RULE_20
               signal_power_reading <= 8'h00;
            end else if (comp > 11'sh0ff) begin
               signal_power_reading <= 8'hff;
            end else begin
               signal_power_reading <= comp[7:0];
            end
         end else begin
            win_cnt_q <= win_cnt_q + 9'h1;
            sum_q     <= sum_all;
         end
      end
   end

   // OOK: strength rises with signal, so compare in the inverted domain.
   logic [7:0] strength, peak_q, ave_q, thr;
   logic [7:0] dec_cnt_q;
   logic       ook_bit_q;
   logic signed [8:0] ave_diff;
   assign strength = 8'hff - level_sample;
   // Signed difference, so the average can move down as well as up.
   assign ave_diff = $signed({1'b0, strength}) - $signed({1'b0, ave_q});
   always_comb begin
      if (sel_q == rx_path_pkg::ONOFF_FIXED) begin
         thr = floor_q; // RULE_19
      end else if (sel_q == rx_path_pkg::ONOFF_AVG) begin
         thr = ave_q; // RULE_19
      end else begin
         thr = ({1'b0, peak_q} > {1'b0, floor_q} + {1'b0, rx_path_pkg::PEAK_DROP})
             ? peak_q - rx_path_pkg::PEAK_DROP : floor_q; // RULE_17
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         peak_q    <= 8'h00;
         ave_q     <= 8'h00;
         dec_cnt_q <= 8'h0;
         ook_bit_q <= 1'b0;
      end else if (level_valid) begin
         ook_bit_q <= strength > thr; // RULE_14
         ave_q     <= ave_q + 8'(ave_diff >>> 3);
         if (strength > peak_q) begin
            peak_q    <= strength;
            dec_cnt_q <= 8'h0;
         end else if (strength <= thr) begin
            if (dec_cnt_q >= {5'h0, period_q}) begin // RULE_17
               dec_cnt_q <= 8'h0;
               // Nine-bit compare: a peak below the floor must not wrap into a huge value.
               if ({1'b0, peak_q} > {1'b0, floor_q} + {6'h0, step_q} + 9'h1 + {1'b0, rx_path_pkg::PEAK_DROP}) begin
                  peak_q <= peak_q - ({5'h0, step_q} + 8'h1);
               end else begin
                  peak_q <= floor_q + rx_path_pkg::PEAK_DROP; // RULE_18
               end
            end else begin
               dec_cnt_q <= dec_cnt_q + 8'h1;
            end
         end
      end
   end

   // FSK path: channel filter, then slice by sign.
   logic                fir_valid;
   logic signed [W-1:0] fir_out;
   logic                fsk_bit_q;
   channel_fir #(.TAPS(TAPS), .W(W)) u_fir ( // RULE_08
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .in_valid   (disc_valid),
      .in_sample  (disc_sample),
      .out_valid  (fir_valid),
      .out_sample (fir_out)
   );
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fsk_bit_q <= 1'b0;
      end else if (fir_valid) begin
         fsk_bit_q <= ~fir_out[W-1];
      end
   end

   // Bit synchronizer: realign on each edge, sample at mid-bit.
   logic        raw, raw_q;
   logic [15:0] bs_cnt_q;
   assign raw = ook_q ? ook_bit_q : fsk_bit_q;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         raw_q    <= 1'b0;
         bs_cnt_q <= 16'h0;
         data_out <= 1'b0;
         data_clk <= 1'b0;
      end else begin
         raw_q <= raw;
         if (!sync_en_q) begin
            data_out <= raw;
            data_clk <= 1'b0;
         end else if (raw != raw_q) begin // RULE_13
            bs_cnt_q <= bit_per_q >> 1;
         end else if (bs_cnt_q == 16'h0) begin
            bs_cnt_q <= bit_per_q - 16'h1;
            data_out <= raw;
            data_clk <= 1'b1;
         end else begin
            bs_cnt_q <= bs_cnt_q - 16'h1;
            if (bs_cnt_q == bit_per_q >> 1) begin
               data_clk <= 1'b0;
            end
         end
      end
   end
endmodule // rx_path

// File: testbench/air_tx_model.sv
// Purpose: Air-side transmitter model feeding power and discriminator samples.
// Assumes: The bench changes its commands just after a rising edge.
// Notes:   Idle power samples carry the inverse of the last level, never a held copy.
`timescale 1ns/10ps
module air_tx_model #(
   parameter logic signed [15:0] DEV = 16'sh2000
) (
   input  wire logic               tx_on,
   input  wire logic [7:0]         tx_level,
   input  wire logic               tx_bit,
   output logic                    level_valid,
   output logic [7:0]              level_sample,
   output logic                    disc_valid,
   output logic signed [15:0]      disc_sample
);
   assign level_valid  = tx_on;
   assign level_sample = tx_on ? tx_level : ~tx_level;
   // Bits last many samples, so the rate stays far below twice the channel bandwidth.
   assign disc_valid   = 1'b1;
   // A quarter-scale level of one sign per bit keeps the index inside the usable span.
   assign disc_sample  = tx_bit ? DEV : -DEV;
endmodule // air_tx_model

// File: testbench/rx_path_properties.sv
// Purpose: Port-level properties of the receive path.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to every rx_path instance.
`timescale 1ns/10ps
module rx_path_properties (
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        level_valid,
   input wire logic [2:0]  front_amp_gain_code,
   input wire logic [7:0]  signal_power_reading
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_rdy_access; pready |-> psel && penable; endproperty
   a_rdy_access: assert property (p_rdy_access) else $error("ready outside access phase");
   property p_one_wait; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
   a_one_wait: assert property (p_one_wait) else $error("ready not after one wait state");
   property p_rdy_pulse; pready |=> !pready; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
   property p_err_rdy; pslverr |-> pready; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
   property p_unmapped; pready && !pwrite && paddr > 8'h18 |-> pslverr && prdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   property p_gain_legal; front_amp_gain_code inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7}; endproperty
   a_gain_legal: assert property (p_gain_legal) else $error("illegal gain code");
   property p_gain_cause; !$stable(front_amp_gain_code) |-> $past(level_valid); endproperty
   a_gain_cause: assert property (p_gain_cause) else $error("gain moved without sample");
   property p_read_hold; !$stable(signal_power_reading) |-> $past(level_valid); endproperty
   a_read_hold: assert property (p_read_hold) else $error("reading moved without sample");
   property p_rd_hold; !$stable(prdata) |-> pready && !pwrite; endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside a read");
endmodule // rx_path_properties

bind rx_path rx_path_properties props (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .level_valid, .front_amp_gain_code, .signal_power_reading);

// File: testbench/rx_path_bench.sv
// Purpose: Self-checking bench for the receive gain, power and demodulator path.
// Assumes: The reading correction is relied on only after a calibration start.
// Notes:   Drivers queue expected values; one monitor compares them when due.
`timescale 1ns/10ps
module rx_path_bench;
   typedef struct {int due; logic [1:0] kind; logic [32:0] exp;} note_t;
   logic               ref_clk = 1'b0;
   logic               nrst, psel, penable, pwrite, pready, pslverr, tx_on, tx_bit;
   logic               level_valid, disc_valid, data_out, data_clk;
   logic [7:0]         paddr, cal_level, tx_level, level_sample, signal_power_reading;
   logic [31:0]        pwdata, prdata;
   logic [2:0]         front_amp_gain_code;
   logic signed [15:0] disc_sample;
   int                 cyc = 0, err_count = 0, samples_checked = 0;
   note_t              q[$];
   logic [32:0]        apq[$];

   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;

   air_tx_model air (.tx_on, .tx_level, .tx_bit, .level_valid, .level_sample, .disc_valid, .disc_sample);
   rx_path #(.TAPS(16), .W(16)) dut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .level_valid, .level_sample, .cal_level, .disc_valid, .disc_sample,
      .front_amp_gain_code, .signal_power_reading, .data_out, .data_clk);

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(string nm, logic [32:0] e, logic [32:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic void push(int d, logic [1:0] k, logic [32:0] e);
      q.push_back('{d, k, e});
   endfunction

   // Reference of -244 half-dB: noise floor, SNR term, reset bandwidth, zero offset.
   function automatic logic [2:0] gain_exp(logic [7:0] l);
      int n;
      n = 0;
      for (int i = 0; i < 5; i++)
         if (-int'(l) > -244 + 2 * int'(i < 4 ? rx_path_pkg::RST_THR14[8*i +: 8] : rx_path_pkg::RST_THR5)) n++;
      return rx_path_pkg::GAIN_CODE[n];
   endfunction

   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && apq.size() > 0)
         chk("read word", apq.pop_front(), {pslverr, prdata});
      while (q.size() > 0 && q[0].due <= cyc) begin
         case (q[0].kind)
            2'h1: chk("gain code", q[0].exp, {30'h0, front_amp_gain_code});
            2'h2: chk("power reading", q[0].exp, {25'h0, signal_power_reading});
            default: chk("data out", q[0].exp, {32'h0, data_out});
         endcase
         void'(q.pop_front());
      end
   end

   task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) apq.push_back(e);
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         $display("Error bus wait expected 1 seen 0");
         err_count++;
         final_report();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic send(logic [7:0] l);
      @(posedge ref_clk);
      tx_on <= 1'b1;
      tx_level <= l;
      push(cyc + 2, 2'h1, {30'h0, gain_exp(l)});
   endtask

   // Strength is 255 minus the level; the result is looked at once the stream is idle.
   task automatic ook(logic [7:0] s, logic e);
      send(8'hff - s);
      push(cyc + 5, 2'h3, {32'h0, e});
      @(posedge ref_clk);
      tx_on <= 1'b0;
      repeat (5) @(posedge ref_clk);
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      $display("Error run length expected 0 seen 1");
      err_count++;
      final_report();
   end

   initial begin
      int         sum, r, n;
      logic [7:0] lv;
      logic [4:0] off;
      logic       dclk_prev;
      {psel, penable, pwrite, tx_on, tx_bit, nrst} = 6'h0;
      {paddr, tx_level, pwdata} = 48'h0;
      cal_level = 8'h50;
      void'($urandom(92));
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      apb(1'b0, 8'h18, 32'h0, 33'h0000001ff);
      apb(1'b1, 8'h0c, 32'h1e, 33'h0);
      apb(1'b0, 8'h0c, 32'h0, 33'h00000000d);
      apb(1'b0, 8'h40, 32'h0, 33'h100000000);
      for (int i = 0; i < 3; i++) begin
         off = i == 0 ? 5'h10 : (i == 1 ? 5'h0f : 5'h03);
         cal_level <= 8'h48 + 8'(i * 8);
         apb(1'b1, 8'h08, {15'h0, 1'b1, 5'h0, 3'(i), 3'h0, off}, 33'h0);
         sum = 0;
         for (int j = 0; j < (2 << i); j++) begin
            lv = (i == 2 && j < 6) ? 8'(230 - 24 * j) : 8'($urandom_range(255));
            sum += lv;
            send(lv);
         end
         r = (sum >> (i + 1)) + int'($signed(off)) + 8 - 8 * i;
         r = r < 0 ? 0 : (r > 255 ? 255 : r);
         push(cyc + 2, 2'h2, 33'(r));
         @(posedge ref_clk);
         tx_on <= 1'b0;
      end
      apb(1'b1, 8'h14, 32'h1, 33'h0);
      apb(1'b1, 8'h10, 32'h4001, 33'h0);
      ook(8'h41, 1'b1);
      ook(8'h40, 1'b0);
      apb(1'b1, 8'h10, 32'h401c, 33'h0);
      repeat (32) send(8'hff);
      ook(8'h41, 1'b1);
      ook(8'h40, 1'b0);
      apb(1'b1, 8'h10, 32'h40e0, 33'h0);
      ook(8'hc8, 1'b1);
      ook(8'hbd, 1'b1);
      ook(8'hbc, 1'b0);
      apb(1'b1, 8'h10, 32'h4002, 33'h0);
      repeat (64) send(8'h9b);
      ook(8'h78, 1'b1);
      ook(8'h50, 1'b0);
      apb(1'b1, 8'h14, 32'h0, 33'h0);
      for (int b = 0; b < 2; b++) begin
         @(posedge ref_clk);
         tx_bit <= b[0];
         repeat (40) @(posedge ref_clk);
         push(cyc + 1, 2'h3, {32'h0, b[0]});
      end
      apb(1'b1, 8'h14, 32'h00100002, 33'h0);
      n = 0;
      dclk_prev = 1'b0;
      for (int k = 0; k < 160; k++) begin
         @(posedge ref_clk);
         tx_bit <= k[4];
         n += int'(data_clk === 1'b1 && dclk_prev === 1'b0);
         dclk_prev = data_clk;
      end
      chk("sync clocks", 33'h1, 33'(n > 8 && n < 12));
      repeat (3) @(posedge ref_clk);
      final_report();
   end
endmodule // rx_path_bench
